// [src/link_width_and_reset_ctrl.sv]
module link_width_and_reset_ctrl #(
    parameter int LANES = 8,
    parameter int APP_CLK_DIV = 2
) (
    input logic ref_clk,
    input logic reset,
    input logic sys_rst_n,
    input logic core_pll_lock,
    input logic [LANES-1:0] xcvr_pll_lock,
    input logic [LANES-1:0] lane_ok,
    input link_ctrl_pkg::lane_width_t partner_width,
    input logic lanes_reversed,
    input logic hot_reset_rx,
    output logic app_clk_out,
    output logic app_rst_out,
    output logic xcvr_rst_out,
    output logic link_up,
    output link_ctrl_pkg::lane_width_t link_width,
    output logic [LANES-1:0] lane_enable,
    output logic lane_reversed_out,
    output logic train_refused,
    output logic link_lost,
    output logic hot_reset_out
);
    import link_ctrl_pkg::*;

    if (!(LANES == 1 || LANES == 2 || LANES == 4 || LANES == 8)) begin : g_bad_lanes
        $error("LANES must be 1, 2, 4 or 8");
    end
    if (APP_CLK_DIV < 1 || APP_CLK_DIV > 255) begin : g_bad_div
        $error("APP_CLK_DIV must be 1 to 255");
    end

    localparam lane_width_t CFG_WIDTH = lane_width_t'(LANES);
    localparam lane_mask_t CFG_MASK = lane_mask_t'((1 << LANES) - 1);
    localparam logic [7:0] DIV_LAST = 8'(APP_CLK_DIV - 1);
    localparam logic [7:0] TRAIN_LOAD = 8'(TRAIN_CYC - 1);
    localparam logic [7:0] RECOV_LOAD = 8'(RECOV_CYC - 1);

    ctrl_s ctrl_reg;
    ctrl_s ctrl_next;
    pins_s pins_raw;
    pins_s f;
    lane_mask_t ok_ext;
    lane_mask_t lock_ext;
    logic rst_cond;
    logic app_edge;

    // unused upper lanes read as dead lanes but locked PLLs
    assign ok_ext = lane_mask_t'(lane_ok);
    assign lock_ext = ~lane_mask_t'(~xcvr_pll_lock);

    assign pins_raw = '{sys_rst_n: sys_rst_n, core_lock: core_pll_lock, hot_reset: hot_reset_rx,
                        reversed: lanes_reversed, partner_width: partner_width,
                        lane_ok: ok_ext, xcvr_lock: lock_ext};

    assign f = ctrl_reg.filt;
    assign rst_cond = ~f.sys_rst_n | ~f.core_lock | ~(&f.xcvr_lock);
    assign app_edge = (ctrl_reg.clk_div == DIV_LAST) && !ctrl_reg.app_clk;

    always_comb begin
        lane_width_t w;
        lane_mask_t fail;
        w = WIDTH_NONE;
        fail = 8'h00;
        ctrl_next = ctrl_reg;

        // three stages; a bit changes only once stages two and three agree
        ctrl_next.s1 = pins_raw;
        ctrl_next.s2 = ctrl_reg.s1;
        ctrl_next.s3 = ctrl_reg.s2;
        ctrl_next.filt = pins_s'((ctrl_reg.s2 & ctrl_reg.s3) | (ctrl_reg.filt & (ctrl_reg.s2 | ctrl_reg.s3)));

        // free-running divider, never touched by the link state
        if (ctrl_reg.clk_div == DIV_LAST) begin
            ctrl_next.clk_div = 8'h00;
            ctrl_next.app_clk = ~ctrl_reg.app_clk;
        end else begin
            ctrl_next.clk_div = ctrl_reg.clk_div + 8'h01;
        end

        if (rst_cond) begin
            ctrl_next.app_rst = 1'b1;
        end else if (app_edge) begin
            ctrl_next.app_rst = 1'b0;
        end

        ctrl_next.xcvr_rst = ~f.sys_rst_n;
        ctrl_next.hot_flag = f.hot_reset;

        if (ctrl_reg.timer != 8'h00) begin
            ctrl_next.timer = ctrl_reg.timer - 8'h01;
        end

        case (ctrl_reg.state)
            ST_HOLD: begin
                ctrl_next.width = WIDTH_NONE;
                ctrl_next.lane_en = 8'h00;
                ctrl_next.reversed = 1'b0;
                if (f.sys_rst_n) begin
                    ctrl_next.state = ST_DETECT;
                end
            end
            ST_DETECT: begin
                if (f.partner_width != WIDTH_NONE && f.lane_ok[0]) begin
                    w = widest_width(f.lane_ok & CFG_MASK, min_width(CFG_WIDTH, f.partner_width));
                    if (f.reversed && w != CFG_WIDTH) begin
                        // partner lane 0 sits on a lane we do not train
                        ctrl_next.train_fail = 1'b1;
                    end else begin
                        ctrl_next.train_fail = 1'b0;
                        ctrl_next.link_lost = 1'b0;
                        ctrl_next.width = w;
                        ctrl_next.lane_en = width_mask(w);
                        ctrl_next.reversed = f.reversed;
                        ctrl_next.timer = TRAIN_LOAD;
                        ctrl_next.state = ST_TRAIN;
                    end
                end
            end
            ST_TRAIN, ST_RECOV: begin
                if (!f.lane_ok[0]) begin
                    ctrl_next.state = ST_DOWN;
                    ctrl_next.link_lost = 1'b1;
                end else if (ctrl_reg.timer == 8'h00) begin
                    ctrl_next.state = ST_UP;
                end
            end
            ST_UP: begin
                fail = ctrl_reg.lane_en & ~f.lane_ok;
                if (fail[0]) begin
                    ctrl_next.state = ST_DOWN;
                    ctrl_next.link_lost = 1'b1;
                end else if (fail != 8'h00) begin
                    if (ctrl_reg.reversed) begin
                        // a narrower reversed link cannot train
                        ctrl_next.state = ST_DOWN;
                        ctrl_next.link_lost = 1'b1;
                    end else begin
                        // capped at the current width, so revived lanes stay idle
                        w = widest_width(f.lane_ok & ctrl_reg.lane_en, ctrl_reg.width);
                        ctrl_next.width = w;
                        ctrl_next.lane_en = width_mask(w);
                        ctrl_next.timer = RECOV_LOAD;
                        ctrl_next.state = ST_RECOV;
                    end
                end
            end
            ST_DOWN: begin
                ctrl_next.width = WIDTH_NONE;
                ctrl_next.lane_en = 8'h00;
                ctrl_next.reversed = 1'b0;
                // only a fresh start from detect can bring back a wider link
                if (f.partner_width == WIDTH_NONE) begin
                    ctrl_next.state = ST_DETECT;
                end
            end
            default: begin
                ctrl_next.state = ST_HOLD;
            end
        endcase

        if (!f.sys_rst_n) begin
            ctrl_next.state = ST_HOLD;
            ctrl_next.width = WIDTH_NONE;
            ctrl_next.lane_en = 8'h00;
            ctrl_next.reversed = 1'b0;
            ctrl_next.train_fail = 1'b0;
            ctrl_next.link_lost = 1'b0;
            ctrl_next.timer = 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_reg <= CTRL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign app_clk_out = ctrl_reg.app_clk;
    // raw pin ORed in so a fundamental reset asserts without waiting for the clock
    assign app_rst_out = ctrl_reg.app_rst | ~sys_rst_n;
    assign xcvr_rst_out = ctrl_reg.xcvr_rst | ~sys_rst_n;
    assign link_up = (ctrl_reg.state == ST_UP);
    assign link_width = ctrl_reg.width;
    assign lane_enable = ctrl_reg.lane_en[LANES-1:0];
    assign lane_reversed_out = ctrl_reg.reversed;
    assign train_refused = ctrl_reg.train_fail;
    assign link_lost = ctrl_reg.link_lost;
    assign hot_reset_out = ctrl_reg.hot_flag;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_lane0_link_lost: assert property (
        (ctrl_reg.state == ST_UP && !f.lane_ok[0] && f.sys_rst_n) |=> (ctrl_reg.state == ST_DOWN && link_lost))
        else $error("lane 0 loss did not drop the link");

    a_no_widen_up: assert property (
        (ctrl_reg.state inside {ST_UP, ST_RECOV} && $past(ctrl_reg.state) inside {ST_UP, ST_RECOV})
        |-> link_width <= $past(link_width))
        else $error("link widened without retraining");

    a_train_min_width: assert property (
        (ctrl_reg.state == ST_TRAIN && $past(ctrl_reg.state) == ST_DETECT)
        |-> (link_width <= $past(f.partner_width) && link_width <= CFG_WIDTH && link_width != WIDTH_NONE))
        else $error("trained width exceeds an advertised width");

    a_reverse_full_width: assert property (
        lane_reversed_out |-> link_width == CFG_WIDTH)
        else $error("reversal with a narrowed width");

    a_reverse_downshift: assert property (
        (ctrl_reg.state == ST_DETECT && f.sys_rst_n && f.reversed && f.lane_ok[0] && f.partner_width != WIDTH_NONE
         && widest_width(f.lane_ok & CFG_MASK, min_width(CFG_WIDTH, f.partner_width)) != CFG_WIDTH)
        |=> (ctrl_reg.state == ST_DETECT && train_refused))
        else $error("reversed downshift link trained");

    a_recov_narrower: assert property (
        (ctrl_reg.state == ST_UP && f.sys_rst_n && f.lane_ok[0] && !ctrl_reg.reversed
         && (ctrl_reg.lane_en & ~f.lane_ok) != 8'h00)
        |=> (ctrl_reg.state == ST_RECOV && link_width < $past(link_width) && link_width != WIDTH_NONE))
        else $error("lane failure did not recover narrower");

    a_app_rst_hold: assert property (
        rst_cond |=> app_rst_out)
        else $error("application reset released while a cause persists");

    a_app_rst_edge: assert property (
        $fell(ctrl_reg.app_rst) |-> ($rose(ctrl_reg.app_clk) && !$past(rst_cond)))
        else $error("application reset released off the clock edge");

    a_xcvr_rst_sys: assert property (
        (!f.sys_rst_n) |=> (xcvr_rst_out && ctrl_reg.state == ST_HOLD && !link_up))
        else $error("system reset did not hold core and transceivers");

    a_train_after_rst: assert property (
        (ctrl_reg.state == ST_HOLD && f.sys_rst_n) |=> ctrl_reg.state == ST_DETECT)
        else $error("training did not start after reset release");

    a_app_clk_steady: assert property (
        (ctrl_reg.app_clk != $past(ctrl_reg.app_clk)) |-> $past(ctrl_reg.clk_div) == DIV_LAST)
        else $error("application clock period changed");

    a_hot_flag: assert property (
        f.hot_reset |=> hot_reset_out)
        else $error("in-band reset not flagged");

    c_full_width: cover property (ctrl_reg.state == ST_UP && link_width == CFG_WIDTH);
    c_recovery: cover property (ctrl_reg.state == ST_UP ##1 ctrl_reg.state == ST_RECOV);
    c_lane0_lost: cover property (ctrl_reg.state == ST_UP ##1 ctrl_reg.state == ST_DOWN);
    c_reversal_refused: cover property ($rose(train_refused));

endmodule

// [src/link_ctrl_pkg.sv]
package link_ctrl_pkg;

    localparam int MAX_LANES = 8;
    localparam int REF_CLK_PERIOD_NS = 25;
    localparam int TRAIN_TIME_NS = 2000;
    localparam int TRAIN_CYC = (TRAIN_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
    localparam int RECOV_TIME_NS = 1000;
    localparam int RECOV_CYC = (RECOV_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;

    typedef logic [3:0] lane_width_t;
    typedef logic [MAX_LANES-1:0] lane_mask_t;

    localparam lane_width_t WIDTH_NONE = 4'h0;
    localparam lane_width_t WIDTH_X1 = 4'h1;
    localparam lane_width_t WIDTH_X2 = 4'h2;
    localparam lane_width_t WIDTH_X4 = 4'h4;
    localparam lane_width_t WIDTH_X8 = 4'h8;

    typedef enum logic [5:0] {
        ST_HOLD   = 6'h01,
        ST_DETECT = 6'h02,
        ST_TRAIN  = 6'h04,
        ST_UP     = 6'h08,
        ST_RECOV  = 6'h10,
        ST_DOWN   = 6'h20
    } link_state_e;

    typedef struct packed {
        logic sys_rst_n;
        logic core_lock;
        logic hot_reset;
        logic reversed;
        lane_width_t partner_width;
        lane_mask_t lane_ok;
        lane_mask_t xcvr_lock;
    } pins_s;

    typedef struct packed {
        pins_s s1;
        pins_s s2;
        pins_s s3;
        pins_s filt;
        link_state_e state;
        lane_width_t width;
        lane_mask_t lane_en;
        logic reversed;
        logic train_fail;
        logic link_lost;
        logic [7:0] timer;
        logic [7:0] clk_div;
        logic app_clk;
        logic app_rst;
        logic xcvr_rst;
        logic hot_flag;
    } ctrl_s;

    localparam pins_s PINS_RST = '{sys_rst_n: 1'b0, core_lock: 1'b0, hot_reset: 1'b0, reversed: 1'b0,
                                   partner_width: 4'h0, lane_ok: 8'h00, xcvr_lock: 8'h00};
    localparam ctrl_s CTRL_RST = '{s1: PINS_RST, s2: PINS_RST, s3: PINS_RST, filt: PINS_RST,
                                   state: ST_HOLD, width: 4'h0, lane_en: 8'h00, reversed: 1'b0,
                                   train_fail: 1'b0, link_lost: 1'b0, timer: 8'h00, clk_div: 8'h00,
                                   app_clk: 1'b0, app_rst: 1'b1, xcvr_rst: 1'b1, hot_flag: 1'b0};

    function automatic lane_width_t min_width(input lane_width_t a, input lane_width_t b);
        return (a < b) ? a : b;
    endfunction

    // widest power-of-two width, up to cap, whose lanes from 0 up all work
    function automatic lane_width_t widest_width(input lane_mask_t ok, input lane_width_t cap);
        if (cap >= WIDTH_X8 && (&ok[7:0])) begin
            return WIDTH_X8;
        end else if (cap >= WIDTH_X4 && (&ok[3:0])) begin
            return WIDTH_X4;
        end else if (cap >= WIDTH_X2 && (&ok[1:0])) begin
            return WIDTH_X2;
        end else if (cap >= WIDTH_X1 && ok[0]) begin
            return WIDTH_X1;
        end else begin
            return WIDTH_NONE;
        end
    endfunction

    function automatic lane_mask_t width_mask(input lane_width_t w);
        lane_mask_t m;
        m = 8'h00;
        for (int i = 0; i < MAX_LANES; i++) begin
            m[i] = (i < int'(w));
        end
        return m;
    endfunction

endpackage

// [tb/link_partner_model.sv]
module link_partner_model (
    input wire logic ref_clk,
    input wire link_ctrl_pkg::lane_width_t adv_width,
    input wire link_ctrl_pkg::lane_mask_t dead_lanes,
    input wire logic flip_lanes,
    output link_ctrl_pkg::lane_width_t partner_width,
    output link_ctrl_pkg::lane_mask_t lane_ok,
    output logic lanes_reversed
);
    timeunit 1ns;
    timeprecision 1ps;
    import link_ctrl_pkg::*;

    initial begin
        partner_width = WIDTH_NONE;
        lane_ok = 8'hff;
        lanes_reversed = 1'b0;
    end

    // shares the endpoint clock, so no power-saving link states are modelled
    // nonblocking on the edge: the endpoint sees each change one edge later, free of races
    always @(posedge ref_clk) begin
        partner_width <= adv_width;
        lane_ok <= ~dead_lanes;
        lanes_reversed <= flip_lanes;
    end
endmodule

// [tb/tb_link_width_and_reset_ctrl.sv]
module tb_link_width_and_reset_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import link_ctrl_pkg::*;

    localparam int DIV = 2;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic sys_rst_n = 1'b1;
    logic core_pll_lock = 1'b1;
    lane_mask_t xcvr_pll_lock = 8'hff;
    logic hot_reset_rx = 1'b0;
    lane_width_t adv = 4'h0;
    lane_mask_t dead = 8'h00;
    logic flip = 1'b0;
    lane_width_t partner_width, link_width;
    lane_mask_t lane_ok, lane_enable;
    logic lanes_reversed, app_clk_out, app_rst_out, xcvr_rst_out, link_up;
    logic lane_reversed_out, train_refused, link_lost, hot_reset_out;
    lane_width_t width4;
    logic [3:0] enable4;
    logic up4;
    int errors = 0;
    int compares = 0;
    int per = 0;
    logic app_q = 1'b0;
    logic per_ok = 1'b0;

    initial begin
        forever #(REF_CLK_PERIOD_NS / 2.0) ref_clk = ~ref_clk;
    end

    link_partner_model far_end (.ref_clk(ref_clk), .adv_width(adv), .dead_lanes(dead), .flip_lanes(flip),
        .partner_width(partner_width), .lane_ok(lane_ok), .lanes_reversed(lanes_reversed));

    link_width_and_reset_ctrl #(.LANES(8), .APP_CLK_DIV(DIV)) DUT (.ref_clk(ref_clk), .reset(reset),
        .sys_rst_n(sys_rst_n), .core_pll_lock(core_pll_lock), .xcvr_pll_lock(xcvr_pll_lock),
        .lane_ok(lane_ok), .partner_width(partner_width), .lanes_reversed(lanes_reversed),
        .hot_reset_rx(hot_reset_rx), .app_clk_out(app_clk_out), .app_rst_out(app_rst_out),
        .xcvr_rst_out(xcvr_rst_out), .link_up(link_up), .link_width(link_width),
        .lane_enable(lane_enable), .lane_reversed_out(lane_reversed_out),
        .train_refused(train_refused), .link_lost(link_lost), .hot_reset_out(hot_reset_out));

    // four-lane core on the same partner, for the narrower-core width rules
    link_width_and_reset_ctrl #(.LANES(4), .APP_CLK_DIV(DIV)) DUT4 (.ref_clk(ref_clk), .reset(reset),
        .sys_rst_n(sys_rst_n), .core_pll_lock(core_pll_lock), .xcvr_pll_lock(xcvr_pll_lock[3:0]),
        .lane_ok(lane_ok[3:0]), .partner_width(partner_width), .lanes_reversed(lanes_reversed),
        .hot_reset_rx(hot_reset_rx), .app_clk_out(), .app_rst_out(), .xcvr_rst_out(), .link_up(up4),
        .link_width(width4), .lane_enable(enable4), .lane_reversed_out(), .train_refused(),
        .link_lost(), .hot_reset_out());

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // bounded wait: training is 80 cycles plus input filtering
    task automatic wait_up();
        for (int i = 0; i < 300 && link_up !== 1'b1; i++) begin
            cyc(1);
        end
        check(16'(link_up), 16'h1);
    endtask

    // widest width from lane 0 upward that the cap and the live lanes allow
    function automatic lane_width_t exp_w(input lane_width_t cap, input lane_mask_t bad);
        if (cap >= 4'h8 && bad == 8'h00) return 4'h8;
        if (cap >= 4'h4 && bad[3:0] == 4'h0) return 4'h4;
        if (cap >= 4'h2 && bad[1:0] == 2'h0) return 4'h2;
        return (bad[0] == 1'b0) ? 4'h1 : 4'h0;
    endfunction

    // lane 0 loss takes down any link, and partner silence leads back to detect
    task automatic go_down();
        dead = 8'h01;
        cyc(8);
        check(16'(link_lost), 16'h1);
        check(16'(link_up), 16'h0);
        adv = 4'h0;
        dead = 8'h00;
        cyc(8);
    endtask

    always @(posedge ref_clk) begin
        app_q <= app_clk_out;
        per <= per + 1;
        if (app_clk_out && !app_q && !reset) begin
            if (per_ok) check(16'(per), 16'(2 * DIV));
            per <= 1;
            per_ok <= 1'b1;
        end
    end

    initial begin
        #(40000 * 25);
        errors++;
        results();
    end

    initial begin
        int k;
        lane_width_t w;
        lane_width_t w4;
        lane_width_t ks[3];
        void'($urandom(46436));
        cyc(10);
        reset = 1'b0;
        cyc(2);
        for (int i = 0; i < 4; i++) begin
            w = 4'(1 << i);
            adv = w;
            wait_up();
            check(16'(link_width), 16'(w));
            check(16'(lane_enable), 16'((16'h1 << w) - 1));
            w4 = (w > 4'h4) ? 4'h4 : w;
            check(16'(up4), 16'h1);
            check(16'(width4), 16'(w4));
            check(16'(enable4), 16'((16'h1 << w4) - 1));
            go_down();
        end
        $display("test negotiation done");
        ks = '{4'h1, 4'h6, 4'(1 + $urandom % 7)};
        foreach (ks[j]) begin
            adv = 4'h8;
            wait_up();
            dead = 8'(8'h01 << ks[j]);
            w = exp_w(4'h8, dead);
            cyc(8);
            check(16'(link_width), 16'(w));
            check(16'(lane_enable), 16'((16'h1 << w) - 1));
            wait_up();
            dead = 8'h00;
            cyc(20);
            check(16'(link_width), 16'(w));
            go_down();
        end
        $display("test lane failure done");
        flip = 1'b1;
        adv = 4'h4;
        cyc(10);
        check(16'(train_refused), 16'h1);
        check(16'(link_up), 16'h0);
        adv = 4'h8;
        wait_up();
        check(16'(lane_reversed_out), 16'h1);
        check(16'(link_width), 16'h8);
        // a reversed link losing an upper lane cannot narrow, so it must drop
        dead = 8'h08;
        cyc(8);
        check(16'(link_lost), 16'h1);
        go_down();
        flip = 1'b0;
        $display("test reversal done");
        adv = 4'h8;
        wait_up();
        hot_reset_rx = 1'b1;
        cyc(6);
        check(16'(hot_reset_out), 16'h1);
        check(16'(app_rst_out), 16'h0);
        check(16'(link_up), 16'h1);
        hot_reset_rx = 1'b0;
        for (int s = 0; s < 2; s++) begin
            k = $urandom % 8;
            if (s == 0) core_pll_lock = 1'b0;
            else xcvr_pll_lock[k] = 1'b0;
            cyc(6);
            check(16'(app_rst_out), 16'h1);
            cyc(20);
            check(16'(app_rst_out), 16'h1);
            core_pll_lock = 1'b1;
            xcvr_pll_lock = 8'hff;
            for (int i = 0; i < 20 && app_rst_out !== 1'b0; i++) cyc(1);
            check(16'(app_rst_out), 16'h0);
            check(16'(app_clk_out), 16'h1);
        end
        sys_rst_n = 1'b0;
        #1;
        check(16'(app_rst_out), 16'h1);
        check(16'(xcvr_rst_out), 16'h1);
        cyc(8);
        check(16'(link_up), 16'h0);
        sys_rst_n = 1'b1;
        wait_up();
        $display("test resets done");
        results();
    end
endmodule
